//--- ssrw_filter.sv
// deglitch filter: output follows input after it is stable for len cycles
// assumes input already synchronous
module ssrw_filter #(
    parameter int len = 2,
    parameter logic init = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    localparam int cw = $clog2(len + 1);
    logic [cw-1:0] cnt;
    wire differs = (d != q);
    wire done = (cnt == cw'(len - 1));
    // count only while input disagrees; any agreement restarts the count
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt <= '0;
            q <= init;
        end else if (!differs) begin
            cnt <= '0;
        end else if (done) begin
            cnt <= '0;
            q <= d;
        end else begin
            cnt <= cnt + cw'(1);
        end
    end
endmodule : ssrw_filter

//--- ssrw_host_model.sv
// host controller and its supply rails, seen from the supervisor's pins
// assumes the bench steers intent: presses, kicks and write wishes
module ssrw_host_model (
    input wire logic clock,
    input wire logic below,
    input wire logic n_oe,
    input wire logic a_oe,
    input wire logic en,
    input wire logic press,
    input wire logic kick_en,
    input wire logic want,
    input wire logic rude,
    output logic rn_in,
    output logic kick = 1'b0,
    output logic wr_req
);
    timeunit 1ns;
    timeprecision 1ps;
    int kick_cnt = 0;
    int stable_cnt = 0;
    // pulled-up reset wire: low while either party pulls it
    assign rn_in = !(n_oe || press);
    // a polite host writes only long after the rail settles and never on a warning;
    // rude is the bench forcing a request to see it refused
    assign wr_req = want && (rude || (en && !a_oe && stable_cnt >= 68));
    // kick toggles every 40 cycles, well inside the watchdog window
    always @(posedge clock) begin
        kick_cnt <= (kick_cnt == 39) ? 0 : kick_cnt + 1;
        if (kick_en && kick_cnt == 39)
            kick <= #1 !kick;
        stable_cnt <= below ? 0 : stable_cnt + 1;
    end
endmodule : ssrw_host_model

//--- ssrw_pkg.sv
// package of timing constants and state types for the supply supervisor
// assumes a 50 MHz clock and comparator indications already digital
package ssrw_pkg;
    localparam int clk_hz = 50_000_000;
    localparam int power_up_reset_timeout_ms = 200;
    localparam int power_up_reset_cycles = power_up_reset_timeout_ms * (clk_hz / 1000);
    localparam int threshold_to_reset_delay_us = 5;
    localparam int threshold_to_reset_cycles = threshold_to_reset_delay_us * (clk_hz / 1_000_000);
    localparam int glitch_reject_width_ns = 30;
    // rounded up to whole cycles, never below one
    localparam int glitch_reject_cycles = (glitch_reject_width_ns * (clk_hz / 1_000_000) + 999) / 1000;
    localparam int sense_to_low_delay_us = 5;
    localparam int sense_to_low_cycles = sense_to_low_delay_us * (clk_hz / 1_000_000);
    localparam int watchdog_timeout_ms = 1600;
    localparam int watchdog_cycles = watchdog_timeout_ms * (clk_hz / 1000);
    localparam int write_cycle_ms = 5;
    localparam int write_cycle_cycles = write_cycle_ms * (clk_hz / 1000);
    typedef enum logic [1:0] {ssrw_hold, ssrw_timeout, ssrw_run} ssrw_state_t;
endpackage : ssrw_pkg

//--- ssrw_sync.sv
// two-flop synchroniser for one level input
// assumes the input may be asynchronous to clock
module ssrw_sync #(
    parameter logic init = 1'b0
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta;
    // first stage is read only by the second stage
    always_ff @(posedge clock) begin
        if (rst) begin
            meta <= init;
            q <= init;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : ssrw_sync

//--- ssrw_top.sv
// supervisor sequencing: reset timing, manual reset, aux low, watchdog, memory inhibit
// assumes comparator outputs are digital, pins resolved by the surroundings
module ssrw_top #(
    parameter bit has_watchdog = 1'b1,
    parameter int power_up_cycles = ssrw_pkg::power_up_reset_cycles,
    parameter int wd_cycles = ssrw_pkg::watchdog_cycles,
    parameter int write_cycles = ssrw_pkg::write_cycle_cycles
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic supply_below_threshold,
    input wire logic aux_sense_input,
    input wire logic reset_n_in,
    output logic reset_n_out,
    output logic reset_n_oe,
    output logic reset_high_out,
    output logic reset_high_oe,
    output logic aux_undervoltage_output,
    output logic aux_undervoltage_oe,
    input wire logic watchdog_kick_input,
    input wire logic mem_txn_active,
    input wire logic mem_write_request,
    output logic mem_enable,
    output logic mem_abort,
    output logic mem_write_busy
);
    localparam int pw = $clog2(power_up_cycles + 1);
    localparam int ww = $clog2(wd_cycles + 1);
    localparam int cw = $clog2(write_cycles + 1);

    // state
    ssrw_pkg::ssrw_state_t state;
    ssrw_pkg::ssrw_state_t next_state;
    logic [pw-1:0] timer;
    logic [ww-1:0] wd_count;
    logic [cw-1:0] wr_count;
    logic pin_prev;
    logic kick_prev;
    // recent drive history; the pin takes two sync stages to show our own release
    logic [1:0] drive_hist;

    // synchronised and filtered inputs
    logic supply_low_sync;
    logic supply_low;
    logic pin_sync;
    logic kick_sync;
    logic sense_sync;

    ssrw_sync #(.init(1'b1)) u_sync_supply (
        .clock(clock), .rst(rst), .d(supply_below_threshold), .q(supply_low_sync)
    );
    // three cycles of agreement is 60 ns, so a 30 ns dip never passes
    ssrw_filter #(.len(ssrw_pkg::glitch_reject_cycles + 1), .init(1'b1)) u_filt_supply (
        .clock(clock), .rst(rst), .d(supply_low_sync), .q(supply_low)
    );
    ssrw_sync #(.init(1'b1)) u_sync_pin (
        .clock(clock), .rst(rst), .d(reset_n_in), .q(pin_sync)
    );
    ssrw_sync #(.init(1'b0)) u_sync_kick (
        .clock(clock), .rst(rst), .d(watchdog_kick_input), .q(kick_sync)
    );
    ssrw_sync #(.init(1'b1)) u_sync_sense (
        .clock(clock), .rst(rst), .d(aux_sense_input), .q(sense_sync)
    );

    // decode of events
    wire in_reset = (state != ssrw_pkg::ssrw_run);
    wire pin_masked = reset_n_oe | drive_hist[0] | drive_hist[1];
    wire pin_fall = pin_prev & ~pin_sync & ~pin_masked;
    wire kick_edge = kick_sync ^ kick_prev;
    wire wd_expired = has_watchdog && (wd_count == ww'(wd_cycles - 1));
    wire timer_done = (timer == pw'(power_up_cycles - 1));
    wire write_start = mem_write_request & ~in_reset & ~mem_write_busy;
    wire write_done = mem_write_busy && (wr_count == cw'(write_cycles - 1));

    // reset sequencer: supply low dominates, any trigger restarts the full timeout
    always_comb begin
        next_state = state;
        case (state)
            ssrw_pkg::ssrw_hold: begin
                if (!supply_low) begin
                    next_state = ssrw_pkg::ssrw_timeout;
                end
            end
            ssrw_pkg::ssrw_timeout: begin
                if (supply_low) begin
                    next_state = ssrw_pkg::ssrw_hold;
                end else if (timer_done) begin
                    next_state = ssrw_pkg::ssrw_run;
                end
            end
            default: begin
                if (supply_low) begin
                    next_state = ssrw_pkg::ssrw_hold;
                end else if (pin_fall || wd_expired) begin
                    next_state = ssrw_pkg::ssrw_timeout;
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ssrw_pkg::ssrw_hold;
        end else begin
            state <= next_state;
        end
    end

    // timeout counter restarts whenever timing is not running
    always_ff @(posedge clock) begin
        if (rst || state != ssrw_pkg::ssrw_timeout || supply_low) begin
            timer <= '0;
        end else if (!timer_done) begin
            timer <= timer + pw'(1);
        end
    end

    // pin edge history; masked while driving and for the sync delay after, so our own
    // low level still in the synchroniser is not mistaken for an outside press
    always_ff @(posedge clock) begin
        if (rst) begin
            pin_prev <= 1'b1;
            kick_prev <= 1'b0;
            drive_hist <= 2'h3;
        end else begin
            pin_prev <= pin_sync | pin_masked;
            kick_prev <= kick_sync;
            drive_hist <= {drive_hist[0], reset_n_oe};
        end
    end

    // watchdog counter, generated away in the variant without the kick input
    generate
        if (has_watchdog) begin : g_wd
            always_ff @(posedge clock) begin
                if (rst || in_reset || kick_edge || wd_expired) begin
                    wd_count <= '0;
                end else begin
                    wd_count <= wd_count + ww'(1);
                end
            end
        end else begin : g_no_wd
            always_ff @(posedge clock) begin
                wd_count <= '0;
            end
        end
    endgenerate

    // internal write cycle: never aborted by reset, so it only ends on its own count
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_write_busy <= 1'b0;
            wr_count <= '0;
        end else if (write_start) begin
            mem_write_busy <= 1'b1;
            wr_count <= '0;
        end else if (write_done) begin
            mem_write_busy <= 1'b0;
        end else if (mem_write_busy) begin
            wr_count <= wr_count + cw'(1);
        end
    end

    // outputs, all registered; reset and memory ones from next state so they move with the state, aux from the synchronised sense
    wire next_in_reset = (next_state != ssrw_pkg::ssrw_run);
    wire next_busy = write_start | (mem_write_busy & ~write_done);
    always_ff @(posedge clock) begin
        if (rst) begin
            reset_n_out <= 1'b0;
            reset_n_oe <= 1'b1;
            reset_high_out <= 1'b1;
            reset_high_oe <= 1'b1;
            aux_undervoltage_output <= 1'b0;
            aux_undervoltage_oe <= 1'b0;
            mem_enable <= 1'b0;
            mem_abort <= 1'b0;
        end else begin
            reset_n_out <= 1'b0;
            reset_high_out <= 1'b1;
            reset_n_oe <= next_in_reset;
            reset_high_oe <= next_in_reset;
            aux_undervoltage_output <= 1'b0;
            aux_undervoltage_oe <= ~sense_sync;
            mem_enable <= ~next_in_reset & ~next_busy;
            mem_abort <= next_in_reset & mem_txn_active;
        end
    end

    // checks
    reset_follows_low_a: assert property (@(posedge clock) disable iff (rst)
        supply_low |=> reset_n_oe) else $error("reset not driven with supply low");
    reset_pair_a: assert property (@(posedge clock) disable iff (rst)
        reset_n_oe == reset_high_oe) else $error("reset outputs disagree");
    mem_off_reset_a: assert property (@(posedge clock) disable iff (rst)
        reset_n_oe |-> !mem_enable) else $error("memory enabled during reset");
    mem_off_write_a: assert property (@(posedge clock) disable iff (rst)
        mem_write_busy |-> !mem_enable) else $error("interface enabled during write");
    abort_txn_a: assert property (@(posedge clock) disable iff (rst)
        (reset_n_oe && $past(mem_txn_active)) |-> mem_abort) else $error("transaction not aborted");
    no_write_reset_a: assert property (@(posedge clock) disable iff (rst)
        (in_reset && !mem_write_busy) |=> !mem_write_busy) else $error("write began in reset");
    write_survives_a: assert property (@(posedge clock) disable iff (rst)
        (mem_write_busy && !write_done) |=> mem_write_busy) else $error("write cut short");
    aux_low_a: assert property (@(posedge clock) disable iff (rst)
        !aux_sense_input [*4] |=> aux_undervoltage_oe) else $error("aux low late");
    wd_held_a: assert property (@(posedge clock) disable iff (rst)
        in_reset |=> wd_count == '0) else $error("watchdog counted in reset");
    release_timed_a: assert property (@(posedge clock) disable iff (rst)
        ($fell(reset_n_oe)) |-> $past(timer_done)) else $error("released before timeout");
    glitch_pass_a: assert property (@(posedge clock) disable iff (rst)
        (state == ssrw_pkg::ssrw_run && !supply_low && !supply_low_sync) |=> !supply_low)
        else $error("short dip passed");
    release_quiet_a: assert property (@(posedge clock) disable iff (rst)
        $fell(reset_n_oe) |-> !pin_fall) else $error("own release seen as press");
endmodule : ssrw_top

//--- test_supply_supervisor_reset_watchdog.sv
// self-checking bench for the supply supervisor sequencing block
// assumes the host model resolves the reset wire, kicks and writes
module test_supply_supervisor_reset_watchdog;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [2:0] id; logic val;} ssrw_note_t;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic below = 1'b1;
    logic aux = 1'b1;
    logic txn = 1'b0;
    logic press = 1'b0;
    logic kick_en = 1'b1;
    logic want = 1'b0;
    logic rude = 1'b0;
    logic rn_in, kick, wr_req, n_oe, h_oe, a_oe, en, ab, busy;
    logic [31:0] seed = 32'hfe62eaa0;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    ssrw_note_t notes[$];
    event noted;
    wire logic [5:0] obs = {busy, ab, en, a_oe, h_oe, n_oe};

    // short counts keep the run small; expectations scale with them
    ssrw_top #(.power_up_cycles(50), .wd_cycles(200), .write_cycles(20)) uut (
        .clock(clock), .rst(rst), .supply_below_threshold(below), .aux_sense_input(aux),
        .reset_n_in(rn_in), .reset_n_out(), .reset_n_oe(n_oe), .reset_high_out(), .reset_high_oe(h_oe),
        .aux_undervoltage_output(), .aux_undervoltage_oe(a_oe), .watchdog_kick_input(kick),
        .mem_txn_active(txn), .mem_write_request(wr_req), .mem_enable(en), .mem_abort(ab),
        .mem_write_busy(busy));
    ssrw_host_model host (.clock, .below, .n_oe, .a_oe, .en, .press, .kick_en, .want, .rude,
        .rn_in, .kick, .wr_req);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // edges pass, then the fixed drive delay
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : tick
    task automatic expect_bit(input logic [2:0] id, input logic val);
        notes.push_back('{id, val});
        -> noted;
    endtask : expect_bit
    // bounded wait for a level, then note it
    task automatic wait_bit(input logic [2:0] id, input logic val, input int max);
        for (int i = 0; i < max && obs[id] !== val; i++)
            tick(1);
        expect_bit(id, val);
    endtask : wait_bit
    task automatic compare_bit(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : compare_bit
    task automatic complete_run;
        // let the monitor drain the last notes first
        #1;
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : complete_run

    // clock at 50 MHz
    initial forever #10 clock = !clock;
    // ceiling well above the expected run of about 1050 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    // monitor: oldest note against the output it names
    initial forever begin
        @(noted);
        while (notes.size() != 0) begin
            compare_bit(obs[notes[0].id], notes[0].val);
            void'(notes.pop_front());
        end
    end
    // power-up, glitch, brownout during a write, aux, manual reset, watchdog
    initial begin
        tick(2);
        rst = 1'b0;
        tick(1);
        expect_bit(3'h0, 1'b1);
        expect_bit(3'h3, 1'b0);
        below = 1'b0;
        tick(33);
        expect_bit(3'h0, 1'b1);
        wait_bit(3'h0, 1'b0, 40);
        tick(2);
        expect_bit(3'h1, 1'b0);
        expect_bit(3'h3, 1'b1);
        below = 1'b1;
        tick(1);
        below = 1'b0;
        tick(10);
        expect_bit(3'h0, 1'b0);
        tick(60);
        want = 1'b1;
        tick(1);
        want = 1'b0;
        tick(2);
        expect_bit(3'h5, 1'b1);
        expect_bit(3'h3, 1'b0);
        txn = 1'b1;
        below = 1'b1;
        tick(10);
        expect_bit(3'h0, 1'b1);
        expect_bit(3'h1, 1'b1);
        expect_bit(3'h4, 1'b1);
        expect_bit(3'h5, 1'b1);
        tick(12);
        expect_bit(3'h5, 1'b0);
        txn = 1'b0;
        rude = 1'b1;
        want = 1'b1;
        tick(3);
        expect_bit(3'h5, 1'b0);
        expect_bit(3'h3, 1'b0);
        want = 1'b0;
        rude = 1'b0;
        below = 1'b0;
        wait_bit(3'h0, 1'b0, 80);
        for (int i = 0; i < 8; i++) begin
            seed = lfsr(seed);
            aux = seed[0];
            tick(8);
            expect_bit(3'h2, !seed[0]);
        end
        press = 1'b1;
        tick(2);
        press = 1'b0;
        tick(6);
        expect_bit(3'h0, 1'b1);
        tick(30);
        expect_bit(3'h0, 1'b1);
        wait_bit(3'h0, 1'b0, 40);
        tick(300);
        expect_bit(3'h0, 1'b0);
        kick_en = 1'b0;
        tick(120);
        expect_bit(3'h0, 1'b0);
        wait_bit(3'h0, 1'b1, 160);
        wait_bit(3'h0, 1'b0, 80);
        tick(120);
        expect_bit(3'h0, 1'b0);
        wait_bit(3'h0, 1'b1, 160);
        complete_run();
    end
endmodule : test_supply_supervisor_reset_watchdog
